//--- rtl/apcr_pkg.sv
// Constants for the audio power and clock control register bank
package apcr_pkg;
  localparam int APCR_NREGS = 10;
  localparam int APCR_AW    = 8;
  localparam int APCR_DW    = 16;

  // Register offsets, one index per word
  localparam logic [7:0] APCR_ADDR_ID   = 8'h00;
  localparam logic [7:0] APCR_ADDR_MICB = 8'h06;
  localparam logic [7:0] APCR_ADDR_MICV = 8'h07;
  localparam logic [7:0] APCR_ADDR_DMIC = 8'h0a;
  localparam logic [7:0] APCR_ADDR_INP  = 8'h0c;
  localparam logic [7:0] APCR_ADDR_HP   = 8'h0e;
  localparam logic [7:0] APCR_ADDR_LO   = 8'h0f;
  localparam logic [7:0] APCR_ADDR_CNV  = 8'h12;
  localparam logic [7:0] APCR_ADDR_CLKA = 8'h14;
  localparam logic [7:0] APCR_ADDR_CLKB = 8'h15;
  localparam logic [7:0] APCR_ADDR_CLKC = 8'h16;

  // Slot numbers of the stored registers
  localparam int APCR_S_MICB = 0;
  localparam int APCR_S_MICV = 1;
  localparam int APCR_S_DMIC = 2;
  localparam int APCR_S_INP  = 3;
  localparam int APCR_S_HP   = 4;
  localparam int APCR_S_LO   = 5;
  localparam int APCR_S_CNV  = 6;
  localparam int APCR_S_CLKA = 7;
  localparam int APCR_S_CLKB = 8;
  localparam int APCR_S_CLKC = 9;

  // Field positions
  localparam int APCR_B_LEFT     = 1;
  localparam int APCR_B_RIGHT    = 0;
  localparam int APCR_B_DETECT   = 1;
  localparam int APCR_B_SUPPLY   = 0;
  localparam int APCR_B_OSR      = 0;
  localparam int APCR_B_CNV_L    = 3;
  localparam int APCR_B_CNV_R    = 2;
  localparam int APCR_B_DMD_L    = 1;
  localparam int APCR_B_DMD_R    = 0;
  localparam int APCR_B_DIV16    = 14;
  localparam int APCR_B_X4       = 13;
  localparam int APCR_B_MDIV     = 0;
  localparam int APCR_B_HALVE    = 12;
  localparam int APCR_F_RATIO_LO = 10;
  localparam int APCR_F_RATE_LO  = 0;

  localparam logic [APCR_AW-1:0] APCR_OFFS [APCR_NREGS] = '{
    APCR_ADDR_MICB, APCR_ADDR_MICV, APCR_ADDR_DMIC, APCR_ADDR_INP, APCR_ADDR_HP,
    APCR_ADDR_LO, APCR_ADDR_CNV, APCR_ADDR_CLKA, APCR_ADDR_CLKB, APCR_ADDR_CLKC};
  // Writable bits; all others read as zero
  localparam logic [APCR_DW-1:0] APCR_MASK [APCR_NREGS] = '{
    16'h0003, 16'h0007, 16'h0001, 16'h0003, 16'h0003,
    16'h0003, 16'h000f, 16'h6001, 16'h3c07, 16'h1000};
  localparam logic [APCR_DW-1:0] APCR_RSTV [APCR_NREGS] = '{
    16'h0000, 16'h0000, 16'h0001, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0c05, 16'h0000};

  // Bias voltage in 100 mV steps
  localparam logic [7:0] APCR_MV_1V6 = 8'h10;
  localparam logic [7:0] APCR_MV_2V0 = 8'h14;
  localparam logic [7:0] APCR_MV_2V1 = 8'h15;
  localparam logic [7:0] APCR_MV_2V4 = 8'h18;
  localparam logic [7:0] APCR_MV_2V7 = 8'h1b;

  localparam logic [10:0] APCR_RATIO_TAB [10] = '{
    11'h040, 11'h080, 11'h0c0, 11'h100, 11'h180,
    11'h200, 11'h300, 11'h400, 11'h580, 11'h600};
  localparam logic [3:0] APCR_RATIO_MAX = 4'h9;
  localparam logic [2:0] APCR_RATE_MAX  = 3'h5;

  // Timeout clock scale as a power of two
  localparam logic signed [3:0] APCR_LOG2_X4    = 4'sh2;
  localparam logic signed [3:0] APCR_LOG2_DIV16 = -4'sh4;
  localparam logic signed [3:0] APCR_LOG2_HALF  = -4'sh1;
endpackage

//--- rtl/apcr_field_reg.sv
// One masked control register with hard and soft reset
`timescale 1ns/1ps
module apcr_field_reg
  import apcr_pkg::*;
#(
  parameter logic [APCR_DW-1:0] MASK = 16'hffff,
  parameter logic [APCR_DW-1:0] RSTV = 16'h0000
)(
  input  wire logic               mclk_i,
  input  wire logic               rst_n_i,
  input  wire logic               soft_rst_i,
  input  wire logic               we_i,
  input  wire logic [APCR_DW-1:0] d_i,
  output logic      [APCR_DW-1:0] q_o
);
  // Soft reset outranks a write; both cannot come in one cycle anyway
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i || soft_rst_i)
      q_o <= RSTV & MASK;
    else if (we_i)
      q_o <= d_i & MASK;
  end
endmodule

//--- rtl/apcr_regs.sv
// Audio power and clock-rate control register bank
`timescale 1ns/1ps
module apcr_regs
  import apcr_pkg::*;
#(
  // Arbitrary identification value
  parameter logic [APCR_DW-1:0] ID_VALUE = 16'h5a3c
)(
  input  wire logic               mclk_i,
  input  wire logic               rst_n_i,
  input  wire logic [APCR_AW-1:0] addr_i,
  input  wire logic [APCR_DW-1:0] wdata_i,
  input  wire logic               wr_i,
  input  wire logic               rd_i,
  output logic      [APCR_DW-1:0] rdata_o,
  output logic                    bias_detect_enable_o,
  output logic                    mic_supply_enable_o,
  output logic      [2:0]         mic_supply_voltage_select_o,
  output logic      [7:0]         mic_supply_level_o,
  output logic                    digital_mic_oversample_select_o,
  output logic                    digital_mic_ready_o,
  output logic                    left_input_amp_enable_o,
  output logic                    right_input_amp_enable_o,
  output logic                    left_headphone_enable_o,
  output logic                    right_headphone_enable_o,
  output logic                    left_line_out_enable_o,
  output logic                    right_line_out_enable_o,
  output logic                    left_converter_enable_o,
  output logic                    right_converter_enable_o,
  output logic                    left_digital_mic_dsp_enable_o,
  output logic                    right_digital_mic_dsp_enable_o,
  output logic                    system_clock_div_two_o,
  output logic      [3:0]         system_clock_to_fs_ratio_o,
  output logic      [10:0]        system_clock_to_fs_multiple_o,
  output logic      [2:0]         sample_rate_select_o,
  output logic                    clock_config_reserved_o,
  output logic                    timeout_clock_div_sixteen_o,
  output logic                    timeout_clock_times_four_o,
  output logic                    timeout_clock_halve_select_o,
  output logic signed [3:0]       timeout_clock_log2_scale_o
);

  logic [APCR_DW-1:0] q [APCR_NREGS];
  logic               soft_rst;
  logic [APCR_DW-1:0] rdata_next;
  logic [7:0]         level_next;
  logic [10:0]        mult_next;
  logic signed [3:0]  scale_next;
  logic [3:0]         ratio_code;
  logic [2:0]         rate_code;

  // Any write to the id word is a full soft reset
  assign soft_rst = wr_i && (addr_i == APCR_ADDR_ID);

  genvar gi;
  generate
    for (gi = 0; gi < APCR_NREGS; gi++)
    begin : g_reg
      apcr_field_reg #(
        .MASK (APCR_MASK[gi]),
        .RSTV (APCR_RSTV[gi])
      ) u_reg (
        .mclk_i     (mclk_i),
        .rst_n_i    (rst_n_i),
        .soft_rst_i (soft_rst),
        .we_i       (wr_i && (addr_i == APCR_OFFS[gi])),
        .d_i        (wdata_i),
        .q_o        (q[gi])
      );
    end
  endgenerate

  // Read data; unmapped offsets answer zero
  always_comb
  begin
    rdata_next = '0;
    if (addr_i == APCR_ADDR_ID)
      rdata_next = ID_VALUE;
    for (int i = 0; i < APCR_NREGS; i++)
    begin
      if (addr_i == APCR_OFFS[i])
        rdata_next = q[i];
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
      rdata_o <= '0;
    else if (rd_i)
      rdata_o <= rdata_next;
    else
      rdata_o <= '0;
  end

  assign ratio_code = q[APCR_S_CLKB][APCR_F_RATIO_LO +: 4];
  assign rate_code  = q[APCR_S_CLKB][APCR_F_RATE_LO +: 3];

  // Bias level; the top code half all map to the highest level
  always_comb
  begin
    case (q[APCR_S_MICV][2:0])
      3'h0:    level_next = APCR_MV_1V6;
      3'h1:    level_next = APCR_MV_2V0;
      3'h2:    level_next = APCR_MV_2V1;
      3'h3:    level_next = APCR_MV_2V4;
      default: level_next = APCR_MV_2V7;
    endcase
  end

  // Ratio codes above the table keep the stored code but give no multiple
  always_comb
  begin
    if (ratio_code <= APCR_RATIO_MAX)
      mult_next = APCR_RATIO_TAB[ratio_code];
    else
      mult_next = '0;
  end

  // Timeout clock scale combines three independent factors
  always_comb
  begin
    scale_next = 4'sh0;
    if (q[APCR_S_CLKA][APCR_B_DIV16])
      scale_next = scale_next + APCR_LOG2_DIV16;
    if (q[APCR_S_CLKA][APCR_B_X4])
      scale_next = scale_next + APCR_LOG2_X4;
    if (!q[APCR_S_CLKC][APCR_B_HALVE])
      scale_next = scale_next + APCR_LOG2_HALF;
  end

  // Mic bias and supply outputs
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      bias_detect_enable_o        <= 1'b0;
      mic_supply_enable_o         <= 1'b0;
      mic_supply_voltage_select_o <= 3'h0;
      mic_supply_level_o          <= APCR_MV_1V6;
    end
    else
    begin
      bias_detect_enable_o        <= q[APCR_S_MICB][APCR_B_DETECT];
      mic_supply_enable_o         <= q[APCR_S_MICB][APCR_B_SUPPLY];
      mic_supply_voltage_select_o <= q[APCR_S_MICV][2:0];
      mic_supply_level_o          <= level_next;
    end
  end

  // Digital mic oversampling; only the cleared setting is usable
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      digital_mic_oversample_select_o <= 1'b1;
      digital_mic_ready_o             <= 1'b0;
    end
    else
    begin
      digital_mic_oversample_select_o <= q[APCR_S_DMIC][APCR_B_OSR];
      digital_mic_ready_o             <= !q[APCR_S_DMIC][APCR_B_OSR];
    end
  end

  // Power enables
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      left_input_amp_enable_o        <= 1'b0;
      right_input_amp_enable_o       <= 1'b0;
      left_headphone_enable_o        <= 1'b0;
      right_headphone_enable_o       <= 1'b0;
      left_line_out_enable_o         <= 1'b0;
      right_line_out_enable_o        <= 1'b0;
      left_converter_enable_o        <= 1'b0;
      right_converter_enable_o       <= 1'b0;
      left_digital_mic_dsp_enable_o  <= 1'b0;
      right_digital_mic_dsp_enable_o <= 1'b0;
    end
    else
    begin
      left_input_amp_enable_o        <= q[APCR_S_INP][APCR_B_LEFT];
      right_input_amp_enable_o       <= q[APCR_S_INP][APCR_B_RIGHT];
      left_headphone_enable_o        <= q[APCR_S_HP][APCR_B_LEFT];
      right_headphone_enable_o       <= q[APCR_S_HP][APCR_B_RIGHT];
      left_line_out_enable_o         <= q[APCR_S_LO][APCR_B_LEFT];
      right_line_out_enable_o        <= q[APCR_S_LO][APCR_B_RIGHT];
      left_converter_enable_o        <= q[APCR_S_CNV][APCR_B_CNV_L];
      right_converter_enable_o       <= q[APCR_S_CNV][APCR_B_CNV_R];
      left_digital_mic_dsp_enable_o  <= q[APCR_S_CNV][APCR_B_DMD_L];
      right_digital_mic_dsp_enable_o <= q[APCR_S_CNV][APCR_B_DMD_R];
    end
  end

  // Clock-rate outputs
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      system_clock_div_two_o       <= 1'b0;
      system_clock_to_fs_ratio_o         <= APCR_RSTV[APCR_S_CLKB][APCR_F_RATIO_LO +: 4];
      system_clock_to_fs_multiple_o      <= APCR_RATIO_TAB[3];
      sample_rate_select_o         <= APCR_RSTV[APCR_S_CLKB][APCR_F_RATE_LO +: 3];
      clock_config_reserved_o      <= 1'b0;
      timeout_clock_div_sixteen_o  <= 1'b0;
      timeout_clock_times_four_o   <= 1'b0;
      timeout_clock_halve_select_o <= 1'b0;
      timeout_clock_log2_scale_o   <= APCR_LOG2_HALF;
    end
    else
    begin
      system_clock_div_two_o       <= q[APCR_S_CLKA][APCR_B_MDIV];
      system_clock_to_fs_ratio_o         <= ratio_code;
      system_clock_to_fs_multiple_o      <= mult_next;
      sample_rate_select_o         <= rate_code;
      clock_config_reserved_o      <= (rate_code > APCR_RATE_MAX)
                                      || (ratio_code > APCR_RATIO_MAX);
      timeout_clock_div_sixteen_o  <= q[APCR_S_CLKA][APCR_B_DIV16];
      timeout_clock_times_four_o   <= q[APCR_S_CLKA][APCR_B_X4];
      timeout_clock_halve_select_o <= q[APCR_S_CLKC][APCR_B_HALVE];
      timeout_clock_log2_scale_o   <= scale_next;
    end
  end

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence s_id_write;
    wr_i && (addr_i == APCR_ADDR_ID);
  endsequence

  sequence s_write_to(logic [7:0] a);
    wr_i && (addr_i == a);
  endsequence

  // Write then effect two edges later, unless reset intervenes
  chk_detect_follows: assert property (
    s_write_to(APCR_ADDR_MICB) ##1 !wr_i ##1 !wr_i
    |-> bias_detect_enable_o == $past(wdata_i[APCR_B_DETECT], 2)
        && mic_supply_enable_o == $past(wdata_i[APCR_B_SUPPLY], 2))
    else $error("mic bias enables do not follow write");

  chk_bias_level_map: assert property (
    (mic_supply_voltage_select_o[2] |-> mic_supply_level_o == APCR_MV_2V7)
    and (mic_supply_voltage_select_o == 3'h3 |-> mic_supply_level_o == APCR_MV_2V4)
    and (mic_supply_voltage_select_o == 3'h2 |-> mic_supply_level_o == APCR_MV_2V1)
    and (mic_supply_voltage_select_o == 3'h1 |-> mic_supply_level_o == APCR_MV_2V0)
    and (mic_supply_voltage_select_o == 3'h0 |-> mic_supply_level_o == APCR_MV_1V6))
    else $error("bias level decode wrong");

  chk_dmic_ready_ok: assert property (
    digital_mic_ready_o != digital_mic_oversample_select_o)
    else $error("dmic ready not inverse of oversample bit");

  chk_dmic_reset_val: assert property (
    $rose(rst_n_i) |-> digital_mic_oversample_select_o)
    else $error("oversample bit not set after reset");

  chk_input_amp_en: assert property (
    s_write_to(APCR_ADDR_INP) ##1 !wr_i ##1 !wr_i
    |-> {left_input_amp_enable_o, right_input_amp_enable_o} == $past(wdata_i[1:0], 2))
    else $error("input amp enables wrong");

  chk_headphone_en: assert property (
    s_write_to(APCR_ADDR_HP) ##1 !wr_i ##1 !wr_i
    |-> {left_headphone_enable_o, right_headphone_enable_o} == $past(wdata_i[1:0], 2))
    else $error("headphone enables wrong");

  chk_line_out_en: assert property (
    s_write_to(APCR_ADDR_LO) ##1 !wr_i ##1 !wr_i
    |-> {left_line_out_enable_o, right_line_out_enable_o} == $past(wdata_i[1:0], 2))
    else $error("line output enables wrong");

  chk_converter_en: assert property (
    s_write_to(APCR_ADDR_CNV) ##1 !wr_i ##1 !wr_i
    |-> {left_converter_enable_o, right_converter_enable_o,
         left_digital_mic_dsp_enable_o, right_digital_mic_dsp_enable_o}
        == $past(wdata_i[3:0], 2))
    else $error("converter enables wrong");

  chk_timeout_scale: assert property (
    ##1 (timeout_clock_div_sixteen_o && !timeout_clock_times_four_o
         && timeout_clock_halve_select_o) |-> timeout_clock_log2_scale_o == -4'sh4)
    else $error("timeout divide by sixteen wrong");

  chk_timeout_halve: assert property (
    ##1 (!timeout_clock_div_sixteen_o && timeout_clock_times_four_o
         && !timeout_clock_halve_select_o) |-> timeout_clock_log2_scale_o == 4'sh1)
    else $error("timeout halve not combined");

  chk_system_clock_div: assert property (
    s_write_to(APCR_ADDR_CLKA) ##1 !wr_i ##1 !wr_i
    |-> system_clock_div_two_o == $past(wdata_i[APCR_B_MDIV], 2))
    else $error("system clock divide bit wrong");

  chk_ratio_decode: assert property (
    (system_clock_to_fs_ratio_o == 4'h8 |-> system_clock_to_fs_multiple_o == 11'h580)
    and (system_clock_to_fs_ratio_o == 4'h9 |-> system_clock_to_fs_multiple_o == 11'h600))
    else $error("ratio decode wrong");

  chk_reserved_flag: assert property (
    sample_rate_select_o[2:1] == 2'h3 |-> clock_config_reserved_o)
    else $error("reserved sample rate not flagged");

  chk_reserved_clear: assert property (
    sample_rate_select_o <= APCR_RATE_MAX && system_clock_to_fs_ratio_o <= APCR_RATIO_MAX
    |-> !clock_config_reserved_o)
    else $error("legal clock codes flagged reserved");

  // Reserved ratio keeps its code, but no multiple may reach the clock logic
  chk_ratio_reserved: assert property (
    system_clock_to_fs_ratio_o > APCR_RATIO_MAX
    |-> clock_config_reserved_o && system_clock_to_fs_multiple_o == 11'h000)
    else $error("reserved ratio not flagged");

  chk_soft_reset: assert property (
    s_id_write ##1 !wr_i ##1 !wr_i
    |-> system_clock_to_fs_ratio_o == 4'h3 && sample_rate_select_o == 3'h5
        && !mic_supply_enable_o && digital_mic_oversample_select_o
        && !left_headphone_enable_o && !right_converter_enable_o)
    else $error("soft reset did not restore defaults");

  chk_read_timing: assert property (
    rd_i && addr_i == APCR_ADDR_ID |=> rdata_o == ID_VALUE)
    else $error("id read wrong");

  chk_idle_rdata: assert property (
    !rd_i |=> rdata_o == '0)
    else $error("read data not zero outside a read");
endmodule

//--- tb/tb_top.sv
// Self-checking testbench for the audio power and clock control register bank
`timescale 1ns/1ps
module tb_top
  import apcr_pkg::*;
;
  // Arbitrary identification value, not tied to any real part
  localparam logic [15:0] ID_EXP = 16'h39c1;

  logic                mclk_i  = 1'b0;
  logic                rst_n_i = 1'b0;
  logic [7:0]          addr_i  = 8'h00;
  logic [15:0]         wdata_i = 16'h0000;
  logic                wr_i    = 1'b0;
  logic                rd_i    = 1'b0;
  logic [15:0]         rdata_o;
  logic                bias_detect_enable_o;
  logic                mic_supply_enable_o;
  logic [2:0]          mic_supply_voltage_select_o;
  logic [7:0]          mic_supply_level_o;
  logic                digital_mic_oversample_select_o;
  logic                digital_mic_ready_o;
  logic                left_input_amp_enable_o;
  logic                right_input_amp_enable_o;
  logic                left_headphone_enable_o;
  logic                right_headphone_enable_o;
  logic                left_line_out_enable_o;
  logic                right_line_out_enable_o;
  logic                left_converter_enable_o;
  logic                right_converter_enable_o;
  logic                left_digital_mic_dsp_enable_o;
  logic                right_digital_mic_dsp_enable_o;
  logic                system_clock_div_two_o;
  logic [3:0]          system_clock_to_fs_ratio_o;
  logic [10:0]         system_clock_to_fs_multiple_o;
  logic [2:0]          sample_rate_select_o;
  logic                clock_config_reserved_o;
  logic                timeout_clock_div_sixteen_o;
  logic                timeout_clock_times_four_o;
  logic                timeout_clock_halve_select_o;
  logic signed [3:0]   timeout_clock_log2_scale_o;

  logic [15:0]         exp_q [$];
  logic                rd_seen = 1'b0;
  logic                started = 1'b0;
  logic [31:0]         seed    = 32'h6ac91460;
  int                  bad_count   = 0;
  int                  check_count = 0;
  int                  cyc         = 0;
  logic [7:0]          lvl  [5]  = '{8'h10, 8'h14, 8'h15, 8'h18, 8'h1b};
  logic [10:0]         mult [10] = '{11'h040, 11'h080, 11'h0c0, 11'h100, 11'h180,
                                     11'h200, 11'h300, 11'h400, 11'h580, 11'h600};

  apcr_regs #(.ID_VALUE(ID_EXP)) u_dut (.*);

  always #2.5 mclk_i = ~mclk_i;

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction

  // Rebuilds a register word from the decoded control outputs
  function automatic logic [15:0] out_of(input int s);
    case (s)
      0: return {14'h0, bias_detect_enable_o, mic_supply_enable_o};
      1: return {13'h0, mic_supply_voltage_select_o};
      2: return {15'h0, digital_mic_oversample_select_o};
      3: return {14'h0, left_input_amp_enable_o, right_input_amp_enable_o};
      4: return {14'h0, left_headphone_enable_o, right_headphone_enable_o};
      5: return {14'h0, left_line_out_enable_o, right_line_out_enable_o};
      6: return {12'h0, left_converter_enable_o, right_converter_enable_o,
                 left_digital_mic_dsp_enable_o, right_digital_mic_dsp_enable_o};
      7: return {1'b0, timeout_clock_div_sixteen_o, timeout_clock_times_four_o, 12'h0,
                 system_clock_div_two_o};
      8: return {2'h0, system_clock_to_fs_ratio_o, 7'h0, sample_rate_select_o};
      9: return {3'h0, timeout_clock_halve_select_o, 12'h0};
      default: return 16'h0000;
    endcase
  endfunction

  task give_verdict;
    if (exp_q.size() != 0)
      bad_count++;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task cmp_read(input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e)
    begin
      bad_count++;
      $display("BAD rdata exp %h got %h", e, g);
    end
  endtask

  task cmp_out(input string what, input logic [15:0] g, input logic [15:0] e);
    check_count++;
    if (g !== e)
    begin
      bad_count++;
      $display("BAD %s exp %h got %h", what, e, g);
    end
  endtask

  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    rd_i    <= 1'b0;
  endtask

  task rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    wr_i   <= 1'b0;
    exp_q.push_back(e);
  endtask

  // Ends 1 ns past the edge so the outputs have settled
  task idle(input int n);
    repeat (n)
    begin
      @(posedge mclk_i);
      wr_i <= 1'b0;
      rd_i <= 1'b0;
    end
    #1;
  endtask

  task chk_defaults;
    for (int s = 0; s < APCR_NREGS; s++)
      cmp_out("default", out_of(s), APCR_RSTV[s]);
    cmp_out("level", {8'h00, mic_supply_level_o}, 16'h0010);
    cmp_out("multiple", {5'h00, system_clock_to_fs_multiple_o}, 16'h0100);
    cmp_out("scale", {{12{timeout_clock_log2_scale_o[3]}}, timeout_clock_log2_scale_o},
            16'hffff);
    cmp_out("ready", {15'h0, digital_mic_ready_o}, 16'h0000);
    for (int s = 0; s < APCR_NREGS; s++)
      rd(APCR_OFFS[s], APCR_RSTV[s]);
    idle(2);
  endtask

  // Read data stand only in the cycle after the strobe, zero otherwise
  always @(posedge mclk_i)
    rd_seen <= rd_i & rst_n_i;

  // Looked at mid-cycle, well away from the edge that launches the data
  always @(negedge mclk_i)
  begin
    if (rd_seen)
      cmp_read(exp_q.size() > 0 ? exp_q.pop_front() : 16'hdead, rdata_o);
    else if (started)
      cmp_read(16'h0000, rdata_o);
  end

  always @(posedge mclk_i)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      bad_count++;
      give_verdict;
    end
  end

  initial
  begin
    logic [15:0] d;
    logic [3:0]  c;
    logic [2:0]  r;
    int          sc;
    repeat (3) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    idle(1);
    started = 1'b1;
    chk_defaults;
    $display("reset defaults done");
    for (int s = 0; s < APCR_NREGS; s++)
    begin
      seed = xs(seed);
      d = seed[15:0];
      wr(APCR_OFFS[s], d);
      rd(APCR_OFFS[s], d & APCR_MASK[s]);
      idle(1);
      cmp_out("outputs", out_of(s), d & APCR_MASK[s]);
    end
    $display("random write and readback done");
    for (int v = 0; v < 8; v++)
    begin
      wr(APCR_ADDR_MICV, 16'(v));
      idle(2);
      cmp_out("level", {8'h00, mic_supply_level_o}, {8'h00, lvl[v > 3 ? 4 : v]});
    end
    wr(APCR_ADDR_DMIC, 16'h0000);
    idle(2);
    cmp_out("ready", {15'h0, digital_mic_ready_o}, 16'h0001);
    $display("bias and oversample done");
    for (int i = 0; i < 16; i++)
    begin
      c = 4'(i);
      r = 3'(i);
      wr(APCR_ADDR_CLKB, {2'b00, c, 7'h00, r});
      idle(2);
      cmp_out("multiple", {5'h00, system_clock_to_fs_multiple_o},
              c <= 4'h9 ? {5'h00, mult[c]} : 16'h0000);
      cmp_out("reserved", {15'h0, clock_config_reserved_o},
              {15'h0, (c > 4'h9) || (r > 3'h5)});
      rd(APCR_ADDR_CLKB, {2'b00, c, 7'h00, r});
    end
    $display("ratio and rate done");
    for (int i = 0; i < 8; i++)
    begin
      r = 3'(i);
      wr(APCR_ADDR_CLKA, {1'b0, r[2], r[1], 13'h0000});
      wr(APCR_ADDR_CLKC, {3'h0, r[0], 12'h000});
      idle(2);
      sc = (r[2] ? -4 : 0) + (r[1] ? 2 : 0) + (r[0] ? 0 : -1);
      cmp_out("scale", {{12{timeout_clock_log2_scale_o[3]}}, timeout_clock_log2_scale_o},
              16'(sc));
    end
    $display("timeout scaling done");
    wr(8'h08, 16'hffff);
    rd(8'h08, 16'h0000);
    rd(8'h13, 16'h0000);
    wr(APCR_ADDR_CLKC, 16'hffff);
    rd(APCR_ADDR_CLKC, 16'h1000);
    rd(APCR_ADDR_ID, ID_EXP);
    idle(2);
    $display("unmapped and id done");
    for (int s = 0; s < APCR_NREGS; s++)
      wr(APCR_OFFS[s], APCR_MASK[s]);
    wr(APCR_ADDR_ID, 16'h0000);
    rd(APCR_ADDR_HP, 16'h0000);
    idle(2);
    chk_defaults;
    $display("soft reset done");
    give_verdict;
  end
endmodule
